// File: rtl/flash_ctl_pkg.sv
// Constants for the flash program/erase control block.
// Assumes a byte-wide internal register bus and one 125 MHz clock.
// Notes on behaviour
// - Control registers take byte accesses only, two bus states each.
// - Gated registers reachable only while the gate bit is one.
// - Flash disabled: gated registers read zero, writes ignored.
// - Gated writes other than power control have no effect while hardware permit reads zero.
// - Mode bit 7 mirrors the hardware permit pin, read-only.
// - Mode register cleared by reset, hardware or software standby.
// - Software permit writable only with hardware permit set.
// - Setup and verify bits need hardware and software permit.
// - Erase bit needs both permits and erase setup.
// - Program bit needs both permits and program setup.
// - Verify modes entered by software permit then the verify bit.
// - Overlay active: reads of chosen block return overlay RAM.
// - Ten erase blocks of the listed sizes, one erased at a time.
// - Erased bytes read as all ones.
// - Error sets the sticky flag; only reset or hardware standby clear.
// - More than one block bit set clears both block registers.
// - Overlay select blocks program and erase everywhere.
package flash_ctl_pkg;
    localparam logic [15:0] SERIAL_EXT_CONTROL_ADDR      = 16'hFDB4;
    localparam logic [15:0] RAM_OVERLAY_SELECT_ADDR      = 16'hFEDB;
    localparam logic [15:0] FLASH_MODE_CONTROL_ADDR      = 16'hFFA8;
    localparam logic [15:0] FLASH_ERROR_STATUS_ADDR      = 16'hFFA9;
    localparam logic [15:0] ERASE_BLOCK_SELECT_LOW_ADDR  = 16'hFFAA;
    localparam logic [15:0] ERASE_BLOCK_SELECT_HIGH_ADDR = 16'hFFAB;
    localparam logic [15:0] FLASH_POWER_CONTROL_ADDR     = 16'hFFAC;

    localparam logic [7:0] REG_RESET_VALUE = 8'h00;
    localparam logic [7:0] ERASED_BYTE     = 8'hFF;

    // Mode control bit positions
    localparam int HW_PERMIT_POS = 7;
    localparam int SW_PERMIT_POS = 6;
    localparam int ERASE_SU_POS  = 5;
    localparam int PROG_SU_POS   = 4;
    localparam int ERASE_VF_POS  = 3;
    localparam int PROG_VF_POS   = 2;
    localparam int ERASE_GO_POS  = 1;
    localparam int PROG_GO_POS   = 0;

    localparam int FLASH_REG_GATE_POS  = 3;
    localparam int ERROR_FLAG_POS      = 7;
    localparam int OVERLAY_SELECT_POS  = 3;
    localparam logic [7:0] OVERLAY_WR_MASK    = 8'h0B;
    localparam logic [7:0] BLOCK_HIGH_WR_MASK = 8'h03;
    localparam logic [7:0] POWER_WR_MASK      = 8'h80;

    localparam int NUM_BLOCKS    = 10;
    localparam int FLASH_AW      = 17;
    localparam int ACCESS_STATES = 2;
    // Block bases, one extra entry marks the array end
    localparam logic [FLASH_AW:0] BLOCK_BASE [NUM_BLOCKS+1] = '{
        18'h0_0000, 18'h0_0400, 18'h0_0800, 18'h0_0C00, 18'h0_1000,
        18'h0_8000, 18'h0_C000, 18'h0_E000, 18'h1_0000, 18'h1_8000,
        18'h2_0000};
endpackage : flash_ctl_pkg

// File: rtl/flash_level_sync.sv
// Two-stage synchroniser for pin levels.
// Assumes inputs are slow, quasi-static levels.
module flash_level_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             REF_CLK_I,
    input  wire logic             RST_N_I,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            meta_reg <= '0;
            q_o      <= '0;
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule : flash_level_sync

// File: rtl/flash_block_map.sv
// Decodes a flash byte address into one-hot erase block hits.
// Assumes the address is below the array end.
module flash_block_map
    import flash_ctl_pkg::*;
(
    input  wire logic [flash_ctl_pkg::FLASH_AW-1:0]   addr_i,
    output logic      [flash_ctl_pkg::NUM_BLOCKS-1:0] hit_o
);
    logic [FLASH_AW:0] addr_ext;

    assign addr_ext = {1'b0, addr_i};

    for (genvar i = 0; i < NUM_BLOCKS; i++) begin : g_blk
        assign hit_o[i] = (addr_ext >= BLOCK_BASE[i]) &&
                          (addr_ext <  BLOCK_BASE[i+1]);
    end
endmodule : flash_block_map

// File: rtl/flash_program_erase_control.sv
// Flash program/erase control registers, overlay read steering, modes.
// Assumes an internal byte bus, one clock, and a same-clock sequencer
// that reports program/erase errors as pulses.
module flash_program_erase_control
    import flash_ctl_pkg::*;
(
    input  wire logic                   REF_CLK_I,
    input  wire logic                   RST_N_I,
    input  wire logic                   REQ_I,
    input  wire logic                   WR_I,
    input  wire logic [15:0]            ADDR_I,
    input  wire logic [7:0]             WDATA_I,
    output logic                        ACK_O,
    output logic      [7:0]             RDATA_O,
    input  wire logic                   HW_WRITE_PERMIT_I,
    input  wire logic                   FLASH_ENABLED_I,
    input  wire logic                   HW_STANDBY_I,
    input  wire logic                   SW_STANDBY_I,
    input  wire logic                   PROG_ERROR_I,
    input  wire logic                   ROM_RD_I,
    input  wire logic [FLASH_AW-1:0]    ROM_ADDR_I,
    input  wire logic [7:0]             ARRAY_DATA_I,
    input  wire logic [7:0]             OVERLAY_DATA_I,
    output logic      [7:0]             ROM_DATA_O,
    output logic                        PROGRAM_MODE_O,
    output logic                        ERASE_MODE_O,
    output logic                        PROGRAM_VERIFY_O,
    output logic                        ERASE_VERIFY_O,
    output logic      [NUM_BLOCKS-1:0]  ERASE_BLOCK_O
);
    import flash_ctl_pkg::*;

    // Bus timing below is built for two-state accesses only
    if (ACCESS_STATES != 2) begin : g_bad_states
        $error("Bus logic serves two states only");
    end

    // Pin levels
    logic hw_write_permit;
    logic flash_en;

    flash_level_sync #(.WIDTH(2)) u_sync (
        .REF_CLK_I (REF_CLK_I),
        .RST_N_I   (RST_N_I),
        .d_i       ({HW_WRITE_PERMIT_I, FLASH_ENABLED_I}),
        .q_o       ({hw_write_permit, flash_en})
    );

    logic [NUM_BLOCKS-1:0] rom_hit;

    flash_block_map u_map (
        .addr_i (ROM_ADDR_I),
        .hit_o  (rom_hit)
    );

    // Bus request state
    logic        busy_reg, busy_next;
    logic        wr_reg, wr_next;
    logic [15:0] addr_reg, addr_next;
    logic [7:0]  wdata_reg, wdata_next;

    always_comb begin
        busy_next  = REQ_I && !busy_reg;
        wr_next    = wr_reg;
        addr_next  = addr_reg;
        wdata_next = wdata_reg;
        if (busy_next) begin
            wr_next    = WR_I;
            addr_next  = ADDR_I;
            wdata_next = WDATA_I;
        end
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            busy_reg  <= 1'b0;
            wr_reg    <= 1'b0;
            addr_reg  <= 16'h0000;
            wdata_reg <= 8'h00;
        end else begin
            busy_reg  <= busy_next;
            wr_reg    <= wr_next;
            addr_reg  <= addr_next;
            wdata_reg <= wdata_next;
        end
    end

    // Control registers
    logic [6:0] mode_reg, mode_next;
    logic       err_reg, err_next;
    logic [7:0] blk_lo_reg, blk_lo_next;
    logic [1:0] blk_hi_reg, blk_hi_next;
    logic [7:0] ovl_reg, ovl_next;
    logic [7:0] gate_reg, gate_next;
    logic       pwr_reg, pwr_next;

    logic       wr_apply, rd_apply, gated_addr, gated_ok, gated_wr_ok;
    logic       sw_on, protect;
    logic [7:0] rdata_next;
    logic [9:0] blk_all;

    assign wr_apply   = busy_reg && wr_reg;
    assign rd_apply   = busy_reg && !wr_reg;
    assign gated_addr = addr_reg inside {FLASH_MODE_CONTROL_ADDR,
                        FLASH_ERROR_STATUS_ADDR, ERASE_BLOCK_SELECT_LOW_ADDR,
                        ERASE_BLOCK_SELECT_HIGH_ADDR,
                        FLASH_POWER_CONTROL_ADDR};
    assign gated_ok    = gate_reg[FLASH_REG_GATE_POS] &&
                         flash_en;
    assign gated_wr_ok = gated_ok && hw_write_permit;
    assign sw_on       = mode_reg[SW_PERMIT_POS];
    assign protect     = ovl_reg[OVERLAY_SELECT_POS] || err_reg;

    always_comb begin
        mode_next   = mode_reg;
        err_next    = err_reg;
        blk_lo_next = blk_lo_reg;
        blk_hi_next = blk_hi_reg;
        ovl_next    = ovl_reg;
        gate_next   = gate_reg;
        pwr_next    = pwr_reg;
        blk_all     = '0;
        if (wr_apply) begin
            unique case (addr_reg)
                SERIAL_EXT_CONTROL_ADDR: gate_next = wdata_reg;
                RAM_OVERLAY_SELECT_ADDR:
                    ovl_next = wdata_reg & OVERLAY_WR_MASK;
                FLASH_MODE_CONTROL_ADDR: if (gated_wr_ok) begin
                    // Each bit checks the pre-write state alone
                    mode_next[SW_PERMIT_POS] =
                        wdata_reg[SW_PERMIT_POS];
                    if (sw_on) begin
                        mode_next[5:2] = wdata_reg[5:2];
                        if (mode_reg[ERASE_SU_POS])
                            mode_next[ERASE_GO_POS] =
                                wdata_reg[ERASE_GO_POS];
                        if (mode_reg[PROG_SU_POS])
                            mode_next[PROG_GO_POS] =
                                wdata_reg[PROG_GO_POS];
                    end
                end
                ERASE_BLOCK_SELECT_LOW_ADDR:
                    if (gated_wr_ok) blk_lo_next = wdata_reg;
                ERASE_BLOCK_SELECT_HIGH_ADDR:
                    if (gated_wr_ok) begin
                        blk_hi_next = wdata_reg[1:0] & BLOCK_HIGH_WR_MASK[1:0];
                    end
                FLASH_POWER_CONTROL_ADDR:
                    if (gated_ok) pwr_next = wdata_reg[7] & POWER_WR_MASK[7];
                default: ;
            endcase
        end
        blk_all = {blk_hi_next, blk_lo_next};
        if ($countones(blk_all) > 1) begin
            blk_lo_next = '0;
            blk_hi_next = '0;
        end
        // Without both permits the block selection is dropped
        if (!hw_write_permit || !mode_next[SW_PERMIT_POS]) begin
            blk_lo_next = '0;
            blk_hi_next = '0;
        end
        // Hardware protection drops all mode bits
        if (!hw_write_permit) mode_next = '0;
        if (HW_STANDBY_I || SW_STANDBY_I) begin
            mode_next   = '0;
            blk_lo_next = '0;
            blk_hi_next = '0;
            pwr_next    = 1'b0;
        end
        if (HW_STANDBY_I) begin
            ovl_next  = REG_RESET_VALUE;
            gate_next = REG_RESET_VALUE;
            err_next  = 1'b0;
        end
        // Set beats the standby clear
        if (PROG_ERROR_I) err_next = 1'b1;
    end

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            mode_reg   <= 7'h00;
            err_reg    <= 1'b0;
            blk_lo_reg <= REG_RESET_VALUE;
            blk_hi_reg <= 2'h0;
            ovl_reg    <= REG_RESET_VALUE;
            gate_reg   <= REG_RESET_VALUE;
            pwr_reg    <= 1'b0;
        end else begin
            mode_reg   <= mode_next;
            err_reg    <= err_next;
            blk_lo_reg <= blk_lo_next;
            blk_hi_reg <= blk_hi_next;
            ovl_reg    <= ovl_next;
            gate_reg   <= gate_next;
            pwr_reg    <= pwr_next;
        end
    end

    // Read data, answered in the second state
    always_comb begin
        rdata_next = 8'h00;
        if (rd_apply) begin
            if (gated_addr && !gated_ok) begin
                rdata_next = 8'h00;
            end else begin
                unique case (addr_reg)
                    SERIAL_EXT_CONTROL_ADDR: rdata_next = gate_reg;
                    RAM_OVERLAY_SELECT_ADDR: rdata_next = ovl_reg;
                    FLASH_MODE_CONTROL_ADDR:
                        rdata_next = {hw_write_permit, mode_reg};
                    FLASH_ERROR_STATUS_ADDR: rdata_next = {err_reg, 7'h00};
                    ERASE_BLOCK_SELECT_LOW_ADDR: rdata_next = blk_lo_reg;
                    ERASE_BLOCK_SELECT_HIGH_ADDR:
                        rdata_next = {6'h00, blk_hi_reg};
                    FLASH_POWER_CONTROL_ADDR: rdata_next = {pwr_reg, 7'h00};
                    default: rdata_next = 8'h00;
                endcase
            end
        end
    end

    // Flash read steering and mode outputs
    logic [7:0]            rom_next;
    logic                  ovl_hit;
    logic [NUM_BLOCKS-1:0] blk_sel;
    logic                  prog_next, erase_next;

    assign ovl_hit = ovl_reg[OVERLAY_SELECT_POS] &&
                     rom_hit[ovl_reg[1:0]];
    assign blk_sel = {blk_hi_next, blk_lo_next};
    assign prog_next  = mode_next[PROG_GO_POS] &&
                        !ovl_next[OVERLAY_SELECT_POS] && !err_next;
    assign erase_next = mode_next[ERASE_GO_POS] &&
                        !ovl_next[OVERLAY_SELECT_POS] && !err_next;

    always_comb begin
        rom_next = ROM_DATA_O;
        if (ROM_RD_I) begin
            if (ovl_hit) rom_next = OVERLAY_DATA_I;
            else if (erase_mode_hit()) rom_next = ERASED_BYTE;
            else rom_next = ARRAY_DATA_I;
        end
    end

    // Block under erase reads as erased while erasing
    function automatic logic erase_mode_hit();
        return ERASE_MODE_O && |(rom_hit & ERASE_BLOCK_O);
    endfunction : erase_mode_hit

    always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            ACK_O            <= 1'b0;
            RDATA_O          <= 8'h00;
            ROM_DATA_O       <= 8'h00;
            PROGRAM_MODE_O   <= 1'b0;
            ERASE_MODE_O     <= 1'b0;
            PROGRAM_VERIFY_O <= 1'b0;
            ERASE_VERIFY_O   <= 1'b0;
            ERASE_BLOCK_O    <= '0;
        end else begin
            ACK_O            <= busy_reg;
            RDATA_O          <= rdata_next;
            ROM_DATA_O       <= rom_next;
            PROGRAM_MODE_O   <= prog_next;
            ERASE_MODE_O     <= erase_next;
            PROGRAM_VERIFY_O <= mode_next[PROG_VF_POS];
            ERASE_VERIFY_O   <= mode_next[ERASE_VF_POS];
            ERASE_BLOCK_O    <= blk_sel;
        end
    end

    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);

    sequence s_taken;
        REQ_I && !busy_reg;
    endsequence

    AST_ACK_TWO_STATES: assert property (
        s_taken |-> ##1 !ACK_O ##1 ACK_O)
        else $error("Access not answered after two states");

    AST_GATE_CLOSED: assert property (
        wr_apply && addr_reg == FLASH_MODE_CONTROL_ADDR && !gated_ok
        |=> mode_reg == $past(mode_reg))
        else $error("Mode register written with gate closed");

    AST_DISABLED_READS_ZERO: assert property (
        rd_apply && gated_addr && !flash_en |=> RDATA_O == 8'h00)
        else $error("Gated read not zero with flash disabled");

    AST_SW_NEEDS_HW: assert property (
        $rose(mode_reg[SW_PERMIT_POS]) |-> $past(hw_write_permit))
        else $error("Software permit set without hardware permit");

    AST_ERASE_ORDER: assert property (
        $rose(mode_reg[ERASE_GO_POS])
        |-> $past(mode_reg[ERASE_SU_POS] && sw_on && hw_write_permit))
        else $error("Erase bit set out of order");

    AST_PROG_ORDER: assert property (
        $rose(mode_reg[PROG_GO_POS])
        |-> $past(mode_reg[PROG_SU_POS] && sw_on && hw_write_permit))
        else $error("Program bit set out of order");

    AST_ONE_BLOCK: assert property (
        $countones({blk_hi_reg, blk_lo_reg}) <= 1)
        else $error("More than one erase block selected");

    AST_ERROR_STICKY: assert property (
        err_reg && !HW_STANDBY_I |=> err_reg)
        else $error("Error flag dropped without hardware standby");

    AST_OVERLAY_BLOCKS: assert property (
        ovl_reg[OVERLAY_SELECT_POS] |-> !PROGRAM_MODE_O && !ERASE_MODE_O)
        else $error("Program or erase active under overlay");

    AST_OVERLAY_READ: assert property (
        ROM_RD_I && ovl_hit |=> ROM_DATA_O == $past(OVERLAY_DATA_I))
        else $error("Overlay block read did not return overlay data");

    AST_STANDBY_CLEARS: assert property (
        SW_STANDBY_I && !PROG_ERROR_I |=> mode_reg == 7'h00)
        else $error("Mode bits survived standby");
endmodule : flash_program_erase_control

// File: verif/flash_program_erase_control_bench.sv
// Self-checking bench for the flash program/erase control registers.
// Assumes the byte register bus of the design; drives all inputs itself.
module flash_program_erase_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import flash_ctl_pkg::*;

    logic                  clk = 1'b0;
    logic                  rst_n;
    logic                  req;
    logic                  wr;
    logic [15:0]           addr;
    logic [7:0]            wdata;
    logic                  ack;
    logic [7:0]            rdata;
    logic                  hw_permit;
    logic                  flash_en;
    logic                  hw_stby;
    logic                  sw_stby;
    logic                  prog_err;
    logic                  rom_strobe;
    logic [FLASH_AW-1:0]   rom_addr;
    logic [7:0]            array_data;
    logic [7:0]            overlay_data;
    logic [7:0]            rom_data;
    logic                  prog_mode;
    logic                  erase_mode;
    logic                  prog_vf;
    logic                  erase_vf;
    logic [NUM_BLOCKS-1:0] erase_blk;
    int                    bad_count;
    int                    compares;

    localparam logic [15:0] MC  = FLASH_MODE_CONTROL_ADDR;
    localparam logic [15:0] LOW = ERASE_BLOCK_SELECT_LOW_ADDR;
    localparam logic [15:0] HI  = ERASE_BLOCK_SELECT_HIGH_ADDR;
    localparam logic [15:0] ERR = FLASH_ERROR_STATUS_ADDR;
    localparam logic [15:0] OVL = RAM_OVERLAY_SELECT_ADDR;
    localparam logic [15:0] PWR = FLASH_POWER_CONTROL_ADDR;
    localparam logic [15:0] SER = SERIAL_EXT_CONTROL_ADDR;

    always #4 clk = ~clk;

    flash_program_erase_control u_dut (
        .REF_CLK_I         (clk),
        .RST_N_I           (rst_n),
        .REQ_I             (req),
        .WR_I              (wr),
        .ADDR_I            (addr),
        .WDATA_I           (wdata),
        .ACK_O             (ack),
        .RDATA_O           (rdata),
        .HW_WRITE_PERMIT_I (hw_permit),
        .FLASH_ENABLED_I   (flash_en),
        .HW_STANDBY_I      (hw_stby),
        .SW_STANDBY_I      (sw_stby),
        .PROG_ERROR_I      (prog_err),
        .ROM_RD_I          (rom_strobe),
        .ROM_ADDR_I        (rom_addr),
        .ARRAY_DATA_I      (array_data),
        .OVERLAY_DATA_I    (overlay_data),
        .ROM_DATA_O        (rom_data),
        .PROGRAM_MODE_O    (prog_mode),
        .ERASE_MODE_O      (erase_mode),
        .PROGRAM_VERIFY_O  (prog_vf),
        .ERASE_VERIFY_O    (erase_vf),
        .ERASE_BLOCK_O     (erase_blk)
    );

    task end_sim;
        $display("Comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Request stands for the taking edge only: a request still up once
    // the answer is out would be taken a second time
    task access(input logic w, input logic [15:0] a,
                input logic [7:0] d, output logic [7:0] q);
        int n;
        @(negedge clk);
        req = 1'b1;
        wr = w;
        addr = a;
        wdata = d;
        @(posedge clk);
        @(negedge clk);
        req = 1'b0;
        // First bus state after the taking edge
        n = 1;
        while (ack !== 1'b1 && n < 6) begin
            @(negedge clk);
            n++;
        end
        q = rdata;
        chk(16'(n), 16'(ACCESS_STATES));
        if (ack !== 1'b1) begin
            bad_count++;
            $display("Error at %0t: no acknowledge", $time);
            end_sim();
        end
    endtask : access

    task wr_reg(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] q;
        access(1'b1, a, d, q);
    endtask : wr_reg

    task rd_reg(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] q;
        access(1'b0, a, 8'h00, q);
        chk({8'h00, q}, {8'h00, exp});
    endtask : rd_reg

    task rom_rd(input logic [FLASH_AW-1:0] a, input logic [7:0] exp);
        @(negedge clk);
        rom_strobe = 1'b1;
        rom_addr = a;
        @(negedge clk);
        rom_strobe = 1'b0;
        chk({8'h00, rom_data}, {8'h00, exp});
    endtask : rom_rd

    task settle;
        repeat (4) @(negedge clk);
    endtask : settle

    initial begin
        rst_n = 1'b0;
        req = 1'b0;
        wr = 1'b0;
        addr = 16'h0000;
        wdata = 8'h00;
        hw_permit = 1'b1;
        flash_en = 1'b1;
        hw_stby = 1'b0;
        sw_stby = 1'b0;
        prog_err = 1'b0;
        rom_strobe = 1'b0;
        rom_addr = '0;
        array_data = 8'h5A;
        overlay_data = 8'hC3;
        bad_count = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        settle();
        rd_reg(MC, 8'h00);
        rd_reg(16'h1234, 8'h00);
        wr_reg(SER, 8'h08);
        rd_reg(SER, 8'h08);
        rd_reg(MC, 8'h80);
        wr_reg(OVL, 8'hFF);
        rd_reg(OVL, OVERLAY_WR_MASK);
        wr_reg(OVL, 8'h00);
        wr_reg(PWR, 8'hFF);
        rd_reg(PWR, POWER_WR_MASK);
        wr_reg(MC, 8'h10);
        rd_reg(MC, 8'h80);
        wr_reg(MC, 8'h40);
        rd_reg(MC, 8'hC0);
        wr_reg(MC, 8'h41);
        rd_reg(MC, 8'hC0);
        // Erase bit refused, permit bit of the same byte still lands
        wr_reg(MC, 8'h42);
        rd_reg(MC, 8'hC0);
        wr_reg(MC, 8'h50);
        rd_reg(MC, 8'hD0);
        wr_reg(MC, 8'h51);
        rd_reg(MC, 8'hD1);
        chk(16'(prog_mode), 16'd1);
        wr_reg(MC, 8'h44);
        chk(16'({prog_vf, erase_vf}), 16'd2);
        wr_reg(MC, 8'h48);
        chk(16'({prog_vf, erase_vf}), 16'd1);
        wr_reg(MC, 8'h40);
        for (int i = 0; i < NUM_BLOCKS; i++) begin
            wr_reg(LOW, 8'h00);
            wr_reg(HI, 8'h00);
            if (i < 8) begin
                wr_reg(LOW, 8'(1 << i));
            end else begin
                wr_reg(HI, 8'(1 << (i - 8)));
            end
            chk(16'(erase_blk), 16'(1 << i));
        end
        // Block 9 still set: a second block bit wipes both
        wr_reg(LOW, 8'h01);
        rd_reg(LOW, 8'h00);
        rd_reg(HI, 8'h00);
        // Block 1 is erased, then the overlay is put over it
        wr_reg(LOW, 8'h02);
        wr_reg(MC, 8'h60);
        wr_reg(MC, 8'h62);
        chk(16'(erase_mode), 16'd1);
        rom_rd(17'h0_07FF, 8'hFF);
        rom_rd(17'h0_0800, 8'h5A);
        wr_reg(OVL, 8'h09);
        rom_rd(17'h0_0400, 8'hC3);
        rom_rd(17'h0_0000, 8'h5A);
        chk(16'(erase_mode), 16'd0);
        rd_reg(MC, 8'hE2);
        wr_reg(OVL, 8'h00);
        chk(16'(erase_mode), 16'd1);
        @(negedge clk);
        prog_err = 1'b1;
        @(negedge clk);
        prog_err = 1'b0;
        rd_reg(ERR, 8'h80);
        chk(16'(erase_mode), 16'd0);
        wr_reg(ERR, 8'h00);
        rd_reg(ERR, 8'h80);
        @(negedge clk);
        sw_stby = 1'b1;
        @(negedge clk);
        sw_stby = 1'b0;
        rd_reg(MC, 8'h80);
        rd_reg(ERR, 8'h80);
        @(negedge clk);
        hw_stby = 1'b1;
        @(negedge clk);
        hw_stby = 1'b0;
        wr_reg(SER, 8'h08);
        rd_reg(ERR, 8'h00);
        // Pin low: permit bit follows after the synchroniser
        wr_reg(MC, 8'h40);
        hw_permit = 1'b0;
        settle();
        rd_reg(MC, 8'h00);
        wr_reg(MC, 8'h40);
        rd_reg(MC, 8'h00);
        wr_reg(LOW, 8'h01);
        rd_reg(LOW, 8'h00);
        hw_permit = 1'b1;
        settle();
        wr_reg(MC, 8'h40);
        flash_en = 1'b0;
        settle();
        rd_reg(MC, 8'h00);
        wr_reg(PWR, 8'h80);
        flash_en = 1'b1;
        settle();
        rd_reg(PWR, 8'h00);
        rd_reg(MC, 8'hC0);
        @(negedge clk);
        rst_n = 1'b0;
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        settle();
        rd_reg(SER, 8'h00);
        // Gate closed: this permit write must not land
        wr_reg(MC, 8'h40);
        wr_reg(SER, 8'h08);
        rd_reg(MC, 8'h80);
        end_sim();
    end
endmodule : flash_program_erase_control_bench
